// >>> verilog/ctp_pkg.sv
`default_nettype none
package ctp_pkg;

  // ===================================================
  // Register byte addresses on the bus
  localparam logic [7:0] ADDR_LOWER_CONTROL     = 8'h00;
  localparam logic [7:0] ADDR_UPPER_CONTROL     = 8'h04;
  localparam logic [7:0] ADDR_WIDTH_LOW_BYTE    = 8'h08;
  localparam logic [7:0] ADDR_WIDTH_HIGH_BYTE   = 8'h0c;
  localparam logic [7:0] ADDR_PERIOD_LOW_BYTE   = 8'h10;
  localparam logic [7:0] ADDR_PERIOD_HIGH_BYTE  = 8'h14;
  localparam logic [7:0] ADDR_STATUS            = 8'h18;

  // ===================================================
  // Control field positions
  localparam int CTL_PRELOAD_BIT = 7;
  localparam int CTL_RUN_BIT     = 3;
  localparam int CTL_SRC_LSB     = 4;
  localparam int CTL_MODE_LSB    = 0;
  localparam int STATUS_FLOP_BIT = 16;

  // ===================================================
  // Reset values
  localparam logic [7:0]  CTL_RESET   = 8'h00;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_FULL  = 16'hffff;

  // ===================================================
  // Lower control mode that cascades the lower counter into the upper
  localparam logic [2:0] LOWER_MODE_CASCADE = 3'h3;

  // Upper control operating modes
  typedef enum logic [2:0] {
    CTP_MODE_TIMER16 = 3'b100,
    CTP_MODE_WARMUP  = 3'b101,
    CTP_MODE_PWM16   = 3'b110,
    CTP_MODE_PULSE16 = 3'b111
  } ctp_mode_t;

  // ===================================================
  // Source clock selections
  localparam logic [2:0] SRC_DIV2K   = 3'h0;
  localparam logic [2:0] SRC_DIV128  = 3'h1;
  localparam logic [2:0] SRC_DIV32   = 3'h2;
  localparam logic [2:0] SRC_DIV8    = 3'h3;
  localparam logic [2:0] SRC_SLOW    = 3'h4;
  localparam logic [2:0] SRC_DIV2    = 3'h5;
  localparam logic [2:0] SRC_DIV1    = 3'h6;
  localparam int         SHIFT_DIV2K  = 11;
  localparam int         SHIFT_DIV128 = 7;
  localparam int         SHIFT_DIV32  = 5;
  localparam int         SHIFT_DIV8   = 3;
  localparam int         SHIFT_DIV2   = 1;

endpackage
`default_nettype wire

// >>> verilog/ctp_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ctp_sync (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      level_q
);

  logic meta_q;
  logic s2_q;
  logic s3_q;

  // ===================================================
  // Three stages; the level only moves once stages two and three agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_q  <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      s2_q   <= meta_q;
      s3_q   <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

endmodule
`default_nettype wire

// >>> verilog/ctp_prescale.sv
`timescale 1ns/10ps
`default_nettype none
module ctp_prescale #(
  parameter int DIV_W = 11
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [2:0] src_sel,
  input  wire logic       slow_rise,
  output logic            tick_q
);

  logic [DIV_W-1:0] div_q;

  // Tick when the low n divider bits are all ones: one tick per 2^n clocks
  function automatic logic ones_low(input logic [DIV_W-1:0] v, input int n);
    logic r;
    r = 1'b1;
    for (int i = 0; i < DIV_W; i++) begin
      if (i < n && !v[i]) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction

  // ===================================================
  // Free running divider shared by every source choice except the slow pin and main clock / 1
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // ===================================================
  // Source select
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_q <= 1'b0;
    end else begin
      case (src_sel)
        ctp_pkg::SRC_DIV2K:  tick_q <= ones_low(div_q, ctp_pkg::SHIFT_DIV2K);
        ctp_pkg::SRC_DIV128: tick_q <= ones_low(div_q, ctp_pkg::SHIFT_DIV128);
        ctp_pkg::SRC_DIV32:  tick_q <= ones_low(div_q, ctp_pkg::SHIFT_DIV32);
        ctp_pkg::SRC_DIV8:   tick_q <= ones_low(div_q, ctp_pkg::SHIFT_DIV8);
        ctp_pkg::SRC_SLOW:   tick_q <= slow_rise;
        ctp_pkg::SRC_DIV2:   tick_q <= ones_low(div_q, ctp_pkg::SHIFT_DIV2);
        ctp_pkg::SRC_DIV1:   tick_q <= 1'b1;
        default:             tick_q <= 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> verilog/ctp_timer.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Lower and upper byte counters run as one sixteen bit up-counter.
// - Pulse mode: width match inverts the output flop, counting continues.
// - Pulse mode: period match inverts flop, clears counter, raises timer_irq.
// - Preload control bit sets the flop's starting level, choosing pulse polarity.
// - Reset clears the output flop to zero.
// - The pulse pin always shows the inverse of the output flop.
// - Pulse mode compare registers act at once; software leaves them alone running.
// - Stopping holds the pin level; only a later preload write or a reset changes it.
// - Upper control: run is bit 3, preload bit 7; clearing 7 drives pin high.
// - Lower control 33H selects main clock divided by eight, cascaded mode.
// - Upper control 056H selects PWM stopped; 05EH also starts it.
// - Upper control 057H selects pulse mode stopped; 05FH also starts it.
// - Warm-up mode times oscillator settling, slow or fast source variant.
// - Warm-up mode compares only the upper period byte; low byte ignored.
// - PWM: width match inverts flop; overflow inverts, clears, raises timer_irq.
// - PWM width writes while running wait in a shadow until the interrupt.
// - Warm-up match clears the counter and raises timer_irq.
module ctp_timer #(
  parameter int DIV_W = 11
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        slow_clk_in,
  output logic             pulse_out_pin,
  output logic             timer_irq
);

  logic [7:0]  lower_control_q;
  logic [7:0]  upper_control_q;
  logic [7:0]  width_low_byte_q;
  logic [7:0]  width_high_byte_q;
  logic [15:0] width_act_q;
  logic [15:0] width_act_d;
  logic [7:0]  period_low_byte_q;
  logic [7:0]  period_high_byte_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        output_flop_q;
  logic        output_flop_d;
  logic        irq_d;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        slow_level;
  logic        slow_prev_q;
  logic        src_tick;
  logic        req;
  logic        wr_go;
  logic        wr_upper;
  logic        run;
  logic        cascaded;
  logic        tick;
  logic        start;
  logic        toggle;
  logic [15:0] period;
  logic        width_match;
  logic        period_match;
  logic        warm_match;
  logic        overflow;
  logic        pwm_run;
  logic [2:0]  mode_bits;
  ctp_pkg::ctp_mode_t mode;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] reg_adr);
    return adr == reg_adr;
  endfunction

  // ===================================================
  // Slow source clock pin
  ctp_sync u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (slow_clk_in),
    .level_q  (slow_level)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      slow_prev_q <= 1'b0;
    end else begin
      slow_prev_q <= slow_level;
    end
  end

  ctp_prescale #(
    .DIV_W (DIV_W)
  ) u_prescale (
    .core_clk  (core_clk),
    .rst       (rst),
    .src_sel   (lower_control_q[ctp_pkg::CTL_SRC_LSB +: 3]),
    .slow_rise (slow_level & ~slow_prev_q),
    .tick_q    (src_tick)
  );

  // ===================================================
  // Bus slave: ack one cycle after the request, write commits with ack
  assign req      = wb_cyc_i & wb_stb_i;
  assign wr_go    = req & wb_we_i & ack_q & wb_sel_i[0];
  assign wr_upper = wr_go & hit(wb_adr_i, ctp_pkg::ADDR_UPPER_CONTROL);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Reads of the width bytes return the shadow copy
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dat_q <= '0;
    end else if (req & ~ack_q & ~wb_we_i) begin
      if (hit(wb_adr_i, ctp_pkg::ADDR_LOWER_CONTROL)) begin
        dat_q <= {24'h000000, lower_control_q};
      end else if (hit(wb_adr_i, ctp_pkg::ADDR_UPPER_CONTROL)) begin
        dat_q <= {24'h000000, upper_control_q};
      end else if (hit(wb_adr_i, ctp_pkg::ADDR_WIDTH_LOW_BYTE)) begin
        dat_q <= {24'h000000, width_low_byte_q};
      end else if (hit(wb_adr_i, ctp_pkg::ADDR_WIDTH_HIGH_BYTE)) begin
        dat_q <= {24'h000000, width_high_byte_q};
      end else if (hit(wb_adr_i, ctp_pkg::ADDR_PERIOD_LOW_BYTE)) begin
        dat_q <= {24'h000000, period_low_byte_q};
      end else if (hit(wb_adr_i, ctp_pkg::ADDR_PERIOD_HIGH_BYTE)) begin
        dat_q <= {24'h000000, period_high_byte_q};
      end else if (hit(wb_adr_i, ctp_pkg::ADDR_STATUS)) begin
        dat_q <= {15'h0000, output_flop_q, cnt_q};
      end else begin
        dat_q <= '0;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ===================================================
  // Control and compare registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lower_control_q    <= ctp_pkg::CTL_RESET;
      upper_control_q    <= ctp_pkg::CTL_RESET;
      width_low_byte_q   <= ctp_pkg::BYTE_RESET;
      width_high_byte_q  <= ctp_pkg::BYTE_RESET;
      period_low_byte_q  <= ctp_pkg::BYTE_RESET;
      period_high_byte_q <= ctp_pkg::BYTE_RESET;
    end else if (wr_go) begin
      if (hit(wb_adr_i, ctp_pkg::ADDR_LOWER_CONTROL)) begin
        lower_control_q <= wb_dat_i[7:0];
      end else if (hit(wb_adr_i, ctp_pkg::ADDR_UPPER_CONTROL)) begin
        upper_control_q <= wb_dat_i[7:0];
      end else if (hit(wb_adr_i, ctp_pkg::ADDR_WIDTH_LOW_BYTE)) begin
        width_low_byte_q <= wb_dat_i[7:0];
      end else if (hit(wb_adr_i, ctp_pkg::ADDR_WIDTH_HIGH_BYTE)) begin
        width_high_byte_q <= wb_dat_i[7:0];
      end else if (hit(wb_adr_i, ctp_pkg::ADDR_PERIOD_LOW_BYTE)) begin
        period_low_byte_q <= wb_dat_i[7:0];
      end else if (hit(wb_adr_i, ctp_pkg::ADDR_PERIOD_HIGH_BYTE)) begin
        period_high_byte_q <= wb_dat_i[7:0];
      end
    end
  end

  // ===================================================
  // Mode decode and compares
  assign run       = upper_control_q[ctp_pkg::CTL_RUN_BIT];
  assign mode_bits = upper_control_q[ctp_pkg::CTL_MODE_LSB +: 3];
  assign mode      = ctp_pkg::ctp_mode_t'(mode_bits);
  // Upper modes only count while the lower half is in cascade
  assign cascaded  = lower_control_q[ctp_pkg::CTL_MODE_LSB +: 3] == ctp_pkg::LOWER_MODE_CASCADE;
  assign tick      = run & cascaded & src_tick;
  assign start     = wr_upper & ~run & wb_dat_i[ctp_pkg::CTL_RUN_BIT];
  assign period    = {period_high_byte_q, period_low_byte_q};
  assign width_match  = cnt_q == width_act_q;
  assign period_match = cnt_q == period;
  assign warm_match   = cnt_q == {period_high_byte_q, 8'h00};
  assign overflow     = cnt_q == ctp_pkg::COUNT_FULL;
  assign pwm_run      = run & (mode == ctp_pkg::CTP_MODE_PWM16);

  // ===================================================
  // Counter and match events
  always_comb begin
    cnt_d  = cnt_q;
    toggle = 1'b0;
    irq_d  = 1'b0;
    if (start) begin
      cnt_d = ctp_pkg::COUNT_RESET;
    end else if (tick) begin
      cnt_d = cnt_q + 16'h0001;
      case (mode)
        ctp_pkg::CTP_MODE_PULSE16: begin
          toggle = width_match ^ period_match;
          if (period_match) begin
            cnt_d = ctp_pkg::COUNT_RESET;
            irq_d = 1'b1;
          end
        end
        ctp_pkg::CTP_MODE_PWM16: begin
          toggle = width_match ^ overflow;
          if (overflow) begin
            cnt_d = ctp_pkg::COUNT_RESET;
            irq_d = 1'b1;
          end
        end
        ctp_pkg::CTP_MODE_WARMUP: begin
          if (warm_match) begin
            cnt_d = ctp_pkg::COUNT_RESET;
            irq_d = 1'b1;
          end
        end
        ctp_pkg::CTP_MODE_TIMER16: begin
          if (period_match) begin
            cnt_d = ctp_pkg::COUNT_RESET;
            irq_d = 1'b1;
          end
        end
        default: begin
          cnt_d = cnt_q;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q     <= ctp_pkg::COUNT_RESET;
      timer_irq <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      timer_irq <= irq_d;
    end
  end

  // ===================================================
  // Active width: shadowed only while PWM runs, direct otherwise
  always_comb begin
    width_act_d = width_act_q;
    if (!pwm_run) begin
      width_act_d = {width_high_byte_q, width_low_byte_q};
    end else if (irq_d) begin
      width_act_d = {width_high_byte_q, width_low_byte_q};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      width_act_q <= ctp_pkg::COUNT_RESET;
    end else begin
      width_act_q <= width_act_d;
    end
  end

  // ===================================================
  // Output flop: preload only from a write made while stopped, so a
  // stopping write never disturbs the held level
  always_comb begin
    output_flop_d = output_flop_q;
    if (wr_upper & ~run) begin
      output_flop_d = wb_dat_i[ctp_pkg::CTL_PRELOAD_BIT];
    end else if (toggle) begin
      output_flop_d = ~output_flop_q;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      output_flop_q <= 1'b0;
      pulse_out_pin <= 1'b1;
    end else begin
      output_flop_q <= output_flop_d;
      pulse_out_pin <= ~output_flop_d;
    end
  end

  // ===================================================
  // Checks
  a_pin_inverse: assert property (@(posedge core_clk) disable iff (rst)
    pulse_out_pin == ~output_flop_q)
    else $error("pin not inverse of flop");

  a_reset_flop_low: assert property (@(posedge core_clk)
    $fell(rst) |-> !output_flop_q && pulse_out_pin)
    else $error("flop not zero after reset");

  a_pulse_width_tog: assert property (@(posedge core_clk) disable iff (rst)
    (tick && !start && mode == ctp_pkg::CTP_MODE_PULSE16 && width_match && !period_match)
    |=> (output_flop_q != $past(output_flop_q)) && (cnt_q == $past(cnt_q) + 16'h0001))
    else $error("width match did not toggle and keep counting");

  a_pulse_period_clr: assert property (@(posedge core_clk) disable iff (rst)
    (tick && !start && mode == ctp_pkg::CTP_MODE_PULSE16 && period_match)
    |=> cnt_q == 16'h0000 && timer_irq ##1 !timer_irq)
    else $error("period match did not clear and interrupt");

  a_pwm_overflow: assert property (@(posedge core_clk) disable iff (rst)
    (tick && !start && mode == ctp_pkg::CTP_MODE_PWM16 && overflow && !width_match)
    |=> cnt_q == 16'h0000 && timer_irq && output_flop_q != $past(output_flop_q))
    else $error("pwm overflow wrong");

  a_warm_match_clr: assert property (@(posedge core_clk) disable iff (rst)
    (tick && !start && mode == ctp_pkg::CTP_MODE_WARMUP && cnt_q[7:0] == 8'h00
     && cnt_q[15:8] == period_high_byte_q) |=> cnt_q == 16'h0000 && timer_irq)
    else $error("warm-up match wrong");

  a_stop_holds_pin: assert property (@(posedge core_clk) disable iff (rst)
    (!run && !wr_upper) [*2] |-> $stable(pulse_out_pin))
    else $error("pin moved while stopped");

  a_start_from_zero: assert property (@(posedge core_clk) disable iff (rst)
    start |=> cnt_q == 16'h0000 && run)
    else $error("start did not zero counter");

  a_idle_no_count: assert property (@(posedge core_clk) disable iff (rst)
    !run && !start |=> $stable(cnt_q) && !timer_irq)
    else $error("counter moved while stopped");

  a_shadow_load: assert property (@(posedge core_clk) disable iff (rst)
    (pwm_run && !irq_d) |=> $stable(width_act_q))
    else $error("pwm width loaded outside interrupt");

  a_bus_ack: assert property (@(posedge core_clk) disable iff (rst)
    (req && !ack_q) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle after request");

endmodule
`default_nettype wire

// >>> dv/tb_ctp_timer.sv
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// Compare helper: counts every check, reports a mismatch at once
`define CTP_CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end

module tb_ctp_timer;
  logic        core_clk;
  logic        rst;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        slow_clk_in;
  logic        pulse_out_pin;
  logic        timer_irq;
  int          error_cnt;
  int          check_count;
  logic [31:0] rd;
  logic [31:0] c1;
  logic        hold_lvl;
  int          per;
  int          low;
  logic [3:0]  slow_div = 4'h0;

  ctp_timer #(.DIV_W(11)) dut (
    .core_clk      (core_clk),
    .rst           (rst),
    .wb_cyc_i      (wb_cyc_i),
    .wb_stb_i      (wb_stb_i),
    .wb_we_i       (wb_we_i),
    .wb_adr_i      (wb_adr_i),
    .wb_sel_i      (wb_sel_i),
    .wb_dat_i      (wb_dat_i),
    .wb_dat_o      (wb_dat_o),
    .wb_ack_o      (wb_ack_o),
    .slow_clk_in   (slow_clk_in),
    .pulse_out_pin (pulse_out_pin),
    .timer_irq     (timer_irq)
  );

  // =====================================================
  // Clock and run control
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Free running slow source oscillator: one rising edge every 16 clocks
  always @(posedge core_clk) begin
    slow_div <= slow_div + 4'h1;
  end

  assign slow_clk_in = slow_div[3];

  task automatic conclude;
    $display("Checks: %0d errors: %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // =====================================================
  // Bus and wait helpers; every wait is bounded
  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [7:0] d,
                          output logic [31:0] q);
    int n;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      `CTP_CHK(wb_ack_o, 1'b1)
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    wb_cycle(1'b1, a, d, x);
  endtask

  task automatic rdr(input logic [7:0] a);
    wb_cycle(1'b0, a, 8'h00, rd);
  endtask

  // Waits for an interrupt, then spans one full period to the next one
  task automatic measure(input int lim);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (timer_irq !== 1'b1 && n < lim);
    per = 0;
    low = 0;
    do begin
      @(posedge core_clk);
      per++;
      if (pulse_out_pin === 1'b0) low++;
    end while (timer_irq !== 1'b1 && per < lim);
    if (timer_irq !== 1'b1) begin
      `CTP_CHK(timer_irq, 1'b1)
      conclude();
    end
  endtask

  // =====================================================
  // Scenarios
  task automatic sc_reset_unmapped;
    `CTP_CHK(pulse_out_pin, 1'b1)
    `CTP_CHK(timer_irq, 1'b0)
    rdr(ctp_pkg::ADDR_STATUS);
    `CTP_CHK(rd[16], 1'b0)
    wr(8'h20, 8'hff);
    rdr(8'h20);
    `CTP_CHK(rd, 32'h00000000)
  endtask

  // Width 3, period 6 at main clock / 8
  task automatic sc_pulse;
    wr(ctp_pkg::ADDR_WIDTH_LOW_BYTE, 8'h03);
    wr(ctp_pkg::ADDR_WIDTH_HIGH_BYTE, 8'h00);
    wr(ctp_pkg::ADDR_PERIOD_LOW_BYTE, 8'h06);
    wr(ctp_pkg::ADDR_PERIOD_HIGH_BYTE, 8'h00);
    wr(ctp_pkg::ADDR_LOWER_CONTROL, 8'h33);
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'h57);
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'h5f);
    measure(2000);
    `CTP_CHK(per, 7 * 8)
    `CTP_CHK(low, 3 * 8)
  endtask

  // Preload of one inverts the pulse; then stop, hold and release the pin
  task automatic sc_preload_stop;
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'h57);
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'hd7);
    repeat (4) @(posedge core_clk);
    `CTP_CHK(pulse_out_pin, 1'b0)
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'hdf);
    measure(2000);
    `CTP_CHK(per, 7 * 8)
    `CTP_CHK(low, 4 * 8)
    repeat (13) @(posedge core_clk);
    // Stop write keeps the preload bit as it was, so the flop must not move
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'hd7);
    repeat (2) @(posedge core_clk);
    hold_lvl = pulse_out_pin;
    rdr(ctp_pkg::ADDR_STATUS);
    c1 = rd;
    repeat (100) @(posedge core_clk);
    `CTP_CHK(pulse_out_pin, hold_lvl)
    rdr(ctp_pkg::ADDR_STATUS);
    `CTP_CHK(rd[15:0], c1[15:0])
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'h57);
    repeat (4) @(posedge core_clk);
    `CTP_CHK(pulse_out_pin, 1'b1)
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'h5f);
    rdr(ctp_pkg::ADDR_STATUS);
    `CTP_CHK(rd[15:1], 15'h0000)
  endtask

  // Compares that need the upper byte: width 0x101, period 0x102 at main clock
  task automatic sc_wide;
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'h57);
    wr(ctp_pkg::ADDR_LOWER_CONTROL, 8'h63);
    wr(ctp_pkg::ADDR_WIDTH_LOW_BYTE, 8'h01);
    wr(ctp_pkg::ADDR_WIDTH_HIGH_BYTE, 8'h01);
    wr(ctp_pkg::ADDR_PERIOD_LOW_BYTE, 8'h02);
    wr(ctp_pkg::ADDR_PERIOD_HIGH_BYTE, 8'h01);
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'h5f);
    measure(2000);
    `CTP_CHK(per, 32'h103)
    `CTP_CHK(low, 1)
  endtask

  // Warm-up: low period byte 0x55 must be ignored, match at 0x0100
  task automatic sc_warmup;
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'h57);
    wr(ctp_pkg::ADDR_PERIOD_LOW_BYTE, 8'h55);
    wr(ctp_pkg::ADDR_PERIOD_HIGH_BYTE, 8'h01);
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'h05);
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'h0d);
    measure(2000);
    `CTP_CHK(per, 32'h101)
    `CTP_CHK(low, 0)
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'h05);
  endtask

  // Plain timer on the slow source pin: period 3 gives four slow edges per interrupt
  task automatic sc_timer16;
    wr(ctp_pkg::ADDR_LOWER_CONTROL, 8'h43);
    wr(ctp_pkg::ADDR_PERIOD_LOW_BYTE, 8'h03);
    wr(ctp_pkg::ADDR_PERIOD_HIGH_BYTE, 8'h00);
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'h04);
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'h0c);
    measure(2000);
    `CTP_CHK(per, 4 * 16)
    `CTP_CHK(low, 0)
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'h04);
    wr(ctp_pkg::ADDR_LOWER_CONTROL, 8'h63);
  endtask

  // PWM: one full 65536-tick period; a width written while running must wait
  task automatic sc_pwm;
    int n;
    wr(ctp_pkg::ADDR_WIDTH_LOW_BYTE, 8'h00);
    wr(ctp_pkg::ADDR_WIDTH_HIGH_BYTE, 8'h01);
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'h56);
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'h5e);
    wr(ctp_pkg::ADDR_WIDTH_LOW_BYTE, 8'h34);
    wr(ctp_pkg::ADDR_WIDTH_HIGH_BYTE, 8'h12);
    rdr(ctp_pkg::ADDR_WIDTH_LOW_BYTE);
    `CTP_CHK(rd[7:0], 8'h34)
    rdr(ctp_pkg::ADDR_WIDTH_HIGH_BYTE);
    `CTP_CHK(rd[7:0], 8'h12)
    n = 0;
    low = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (pulse_out_pin === 1'b0) low++;
    end while (timer_irq !== 1'b1 && n < 70000);
    `CTP_CHK(timer_irq, 1'b1)
    if (timer_irq !== 1'b1) begin
      conclude();
    end
    // Pin falls near tick 0x101, so low time is the rest of the period
    `CTP_CHK((low >= 65271 && low <= 65287), 1'b1)
    repeat (3) @(posedge core_clk);
    `CTP_CHK(pulse_out_pin, 1'b1)
    rdr(ctp_pkg::ADDR_STATUS);
    `CTP_CHK(rd[15:4], 12'h000)
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'h56);
  endtask

  task automatic sc_mid_reset;
    wr(ctp_pkg::ADDR_UPPER_CONTROL, 8'hd7);
    repeat (4) @(posedge core_clk);
    `CTP_CHK(pulse_out_pin, 1'b0)
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    `CTP_CHK(pulse_out_pin, 1'b1)
    rdr(ctp_pkg::ADDR_STATUS);
    `CTP_CHK(rd[16], 1'b0)
  endtask

  // =====================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h00000000;
    error_cnt = 0;
    check_count = 0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    sc_reset_unmapped();
    sc_pulse();
    sc_preload_stop();
    sc_wide();
    sc_warmup();
    sc_timer16();
    sc_pwm();
    sc_mid_reset();
    conclude();
  end
endmodule
`default_nettype wire
